/* common/tdss_pkg.sv */
// Shared constants and carriers for the transmit descriptor word 1/2 block.
// Assumes 16-bit word-wide shared buffer RAM with 24-bit byte addresses.
package tdss_pkg;

  // ----------------------------------------------------------------
  // Descriptor layout
  // ----------------------------------------------------------------
  localparam logic [23:0] DESC_W0_OFFSET  = 24'h000000;
  localparam logic [23:0] DESC_W1_OFFSET  = 24'h000002;
  localparam logic [23:0] DESC_W2_OFFSET  = 24'h000004;
  localparam int          DESC_SHIFT      = 3;
  localparam int          OWN_BIT         = 15;
  localparam int          ERR_BIT         = 14;
  localparam int          RSV_BIT         = 13;
  localparam int          MULTI_BIT       = 12;
  localparam int          SINGLE_BIT      = 11;
  localparam int          DEFER_BIT       = 10;
  localparam int          FIRST_BIT       = 9;
  localparam int          LAST_BIT        = 8;
  localparam int          ADDR_HI_MSB     = 7;
  localparam int          LEN_MSB         = 11;
  localparam logic [4:0]  RETRY_LIMIT     = 5'h10;
  localparam logic [6:0]  PTR_RESET       = 7'h00;
  localparam logic [15:0] WORD_RESET      = 16'h0000;
  localparam logic [23:0] ADDR_RESET      = 24'h000000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic        we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } tdss_mem_req_s;

  typedef struct packed {
    logic [23:0] start_addr;
    logic [11:0] length;
    logic        first;
    logic        last;
    logic        whole;
  } tdss_buf_s;

  typedef struct packed {
    logic       late_collision;
    logic       carrier_loss;
    logic       underflow;
    logic       deferred;
    logic [4:0] retry_count;
  } tdss_status_s;

  typedef enum logic [2:0] {
    TDSS_IDLE,
    TDSS_RD_W1,
    TDSS_RD_W0,
    TDSS_RD_W2,
    TDSS_SEND,
    TDSS_WR_W1,
    TDSS_ADVANCE
  } tdss_state_e;

endpackage : tdss_pkg

/* dv/tdss_engine_properties.sv */
// Checker for the transmit descriptor engine, bound to its top module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module tdss_engine_properties (
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    rstn,
  // Configuration
  input wire logic [23:0]             ring_base,
  input wire logic [2:0]              ring_len_log2,
  // Buses
  input wire tdss_pkg::tdss_mem_req_s mem_req,
  input wire tdss_pkg::tdss_buf_s     buf_info,
  input wire logic                    buf_valid,
  input wire logic                    tx_done,
  input wire tdss_pkg::tdss_status_s  tx_status,
  // Status
  input wire logic [6:0]              ring_ptr,
  input wire logic                    desc_error,
  input wire logic                    desc_returned
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  tdss_pkg::tdss_status_s st_q;
  tdss_pkg::tdss_buf_s    bi_q;
  logic                   wr;
  logic                   err_now;
  logic [6:0]             mask;
  assign wr = mem_req.req && mem_req.we;
  assign mask = 7'((8'h1 << ring_len_log2) - 8'h1);
  assign err_now = tx_status.late_collision || tx_status.carrier_loss ||
                   tx_status.underflow || (tx_status.retry_count >= 5'h10);
  // Status is gone once tx_done passes, so keep it for the write back
  always_ff @(posedge core_clk) begin
    if (buf_valid && tx_done) begin
      st_q <= tx_status;
      bi_q <= buf_info;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_own_clear; wr |-> !mem_req.wdata[15]; endproperty
  a_own_clear: assert property (p_own_clear)
    else $error("write back leaves ownership set");
  property p_rsv_zero; wr |-> !mem_req.wdata[13]; endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved bit written as one");
  property p_len_addr;
    $rose(buf_valid) |-> $past(mem_req.addr) ==
      ring_base + {14'h0, ring_ptr, 3'h4};
  endproperty
  a_len_addr: assert property (p_len_addr)
    else $error("length word fetched from wrong address");
  property p_ptr;
    desc_returned |-> ring_ptr == (($past(ring_ptr) + 7'h1) & mask);
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("ring pointer not advanced modulo ring size");
  property p_whole;
    buf_valid |-> buf_info.whole == (buf_info.first && buf_info.last);
  endproperty
  a_whole: assert property (p_whole)
    else $error("whole packet flag wrong");
  property p_err;
    buf_valid && tx_done |=> desc_error == $past(err_now);
  endproperty
  a_err: assert property (p_err)
    else $error("error summary wrong");
  property p_multi; wr && st_q.retry_count > 5'h1 |-> mem_req.wdata[12]; endproperty
  a_multi: assert property (p_multi)
    else $error("multi retry flag missing");
  property p_single; wr && st_q.retry_count == 5'h1 |-> mem_req.wdata[11];
  endproperty
  a_single: assert property (p_single)
    else $error("single retry flag missing");
  property p_keep;
    wr |-> mem_req.wdata[9:0] ==
      {bi_q.first, bi_q.last, bi_q.start_addr[23:16]};
  endproperty
  a_keep: assert property (p_keep)
    else $error("host owned bits altered");
  cover property (buf_valid && tx_done);
  cover property (desc_returned && ring_ptr == 7'h0);
  cover property (wr && st_q.retry_count >= 5'h10);
endmodule : tdss_engine_properties

bind tdss_engine tdss_engine_properties u_props (.*);

/* dv/tdss_engine_tb.sv */
// Testbench for the transmit descriptor engine with a RAM model.
// Assumes a four entry ring at byte base 0x10.
`timescale 1ns/10ps
module tdss_engine_tb;
  logic core_clk, rstn, tx_enable, mem_ack, buf_valid, tx_done;
  logic retries_exhausted, desc_error, desc_returned;
  logic [23:0] ring_base;
  logic [2:0]  ring_len_log2;
  logic [15:0] mem_rdata;
  logic [6:0]  ring_ptr;
  logic [3:0]  wait_cycles;
  tdss_pkg::tdss_mem_req_s mem_req;
  tdss_pkg::tdss_buf_s     buf_info;
  tdss_pkg::tdss_status_s  tx_status;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  tdss_engine DUT (.core_clk(core_clk), .rstn(rstn), .tx_enable(tx_enable),
    .ring_base(ring_base), .ring_len_log2(ring_len_log2), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .buf_info(buf_info),
    .buf_valid(buf_valid), .tx_done(tx_done), .tx_status(tx_status),
    .ring_ptr(ring_ptr), .retries_exhausted(retries_exhausted),
    .desc_error(desc_error), .desc_returned(desc_returned));
  tdss_ram_model u_ram (.core_clk(core_clk), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .wait_cycles(wait_cycles));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Bounded wait on the offer level or the return pulse
  task automatic wait_sig(input bit ret);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (((ret ? desc_returned : buf_valid) !== 1'b1) && n < 300);
    chk("handshake", 24'h1, 24'(n < 300));
  endtask : wait_sig
  task automatic t_not_owned();
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(posedge core_clk);
      #1;
      seen = seen | buf_valid;
    end
    chk("offered while host owned", 24'h0, 24'(seen));
  endtask : t_not_owned
  task automatic t_packet(input logic [15:0] w0, input logic [15:0] w1,
    input logic [11:0] len, input tdss_pkg::tdss_status_s st,
    input logic [3:0] wc);
    int i;
    logic err;
    logic [15:0] exp;
    logic [6:0] nxt;
    wait_cycles = wc;
    i = 8 + 4 * ring_ptr;
    nxt = 7'((ring_ptr + 7'h1) & 7'h3);
    u_ram.ram[i] = w0;
    u_ram.ram[i+2] = {4'hf, 12'h000 - len};
    u_ram.ram[i+1] = {1'b1, w1[14:0]};
    wait_sig(1'b0);
    chk("start_addr", {w1[7:0], w0}, buf_info.start_addr);
    chk("length", 24'(len), 24'(buf_info.length));
    chk("whole", 24'(w1[9] & w1[8]), 24'(buf_info.whole));
    chk("first", 24'(w1[9]), 24'(buf_info.first));
    chk("last", 24'(w1[8]), 24'(buf_info.last));
    err = st.late_collision | st.carrier_loss | st.underflow |
          (st.retry_count >= 5'h10);
    @(posedge core_clk);
    tx_done <= 1'b1;
    tx_status <= st;
    @(posedge core_clk);
    tx_done <= 1'b0;
    #1;
    chk("desc_error", 24'(err), 24'(desc_error));
    exp = {1'b0, w1[14] | err, 1'b0, w1[12] | (st.retry_count > 5'h1),
           w1[11] | (st.retry_count == 5'h1), w1[10] | st.deferred, w1[9:0]};
    wait_sig(1'b1);
    chk("word1", 24'(exp), 24'(u_ram.ram[i+1]));
    chk("word2", {8'h00, 4'hf, 12'h000 - len}, 24'(u_ram.ram[i+2]));
    chk("exhausted", 24'(st.retry_count >= 5'h10), 24'(retries_exhausted));
    chk("ring_ptr", 24'(nxt), 24'(ring_ptr));
  endtask : t_packet
  initial begin
    rstn = 1'b0;
    tx_enable = 1'b0;
    ring_base = 24'h000010;
    ring_len_log2 = 3'h2;
    tx_done = 1'b0;
    tx_status = '0;
    wait_cycles = 4'h0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    tx_enable <= 1'b1;
    t_not_owned();
    t_packet(16'h1234, 16'h0345, 12'h040, '{1'b0, 1'b0, 1'b0, 1'b0, 5'h00},
             4'h0);
    t_packet(16'h8000, 16'h0277, 12'h5ee, '{1'b0, 1'b0, 1'b0, 1'b1, 5'h01},
             4'h3);
    t_packet(16'h0042, 16'h0100, 12'h064, '{1'b1, 1'b0, 1'b0, 1'b0, 5'h03},
             4'h1);
    t_packet(16'hbeef, 16'h7c0a, 12'h0c8, '{1'b0, 1'b1, 1'b0, 1'b0, 5'h10},
             4'h2);
    t_packet(16'h0002, 16'h0300, 12'h041, '{1'b0, 1'b0, 1'b1, 1'b0, 5'h02},
             4'h0);
    close_out();
  end
endmodule : tdss_engine_tb

/* dv/tdss_ram_model.sv */
// Shared buffer RAM model acting for the host side of the descriptors.
// Assumes word addressing through byte address bits 6:1.
`timescale 1ns/10ps
module tdss_ram_model (
  // Clock
  input wire logic                    core_clk,
  // Bus
  input wire tdss_pkg::tdss_mem_req_s mem_req,
  output logic                        mem_ack,
  output logic [15:0]                 mem_rdata,
  // Pacing
  input wire logic [3:0]              wait_cycles
);
  logic [15:0] ram [0:63];
  logic [3:0]  cnt;
  initial begin
    foreach (ram[i]) ram[i] = 16'h0000;
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
    cnt = 4'h0;
  end
  // Read data is scrambled outside the ack cycle so nobody leans on it
  always @(posedge core_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req.req && !mem_ack) begin
      if (cnt == wait_cycles) begin
        cnt <= 4'h0;
        mem_ack <= 1'b1;
        if (mem_req.we) ram[mem_req.addr[6:1]] <= mem_req.wdata;
        else mem_rdata <= ram[mem_req.addr[6:1]];
      end else cnt <= cnt + 4'h1;
    end
  end
endmodule : tdss_ram_model

/* logic/tdss_engine.sv */
// Transmit descriptor engine: polls word 1 of the current descriptor,
// fetches address and length, hands the buffer to the transmit engine,
// writes status back into word 1 and returns ownership to the host.
// Assumes the RAM and transmit engine share core_clk; no pin crossing.
`timescale 1ns/10ps

// Function
// - Bit 15 set means controller owns descriptor
// - Clear ownership when finished with buffer
// - Ownership change is the final write
// - No descriptor writes after ownership returned
// - Error bit is OR of four errors
// - Reserved bit 13 written as zero
// - Multi-retry flag for more than one retry
// - Single-retry flag for exactly one retry
// - Deferral flag when network was busy
// - First-buffer flag never changed by controller
// - Last-buffer flag never changed by controller
// - First and last set means whole packet
// - Word 1 low byte is address high
// - Word 2 low field is negated length
// - Length word at ring base plus 8n+4
// - Low address from word 0 joined high
// - Retries exhausted after 16 collision failures
// - Advance ring pointer modulo ring size
module tdss_engine (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // Configuration
  input  wire logic                  tx_enable,
  input  wire logic [23:0]           ring_base,
  input  wire logic [2:0]            ring_len_log2,
  // Shared buffer RAM
  output tdss_pkg::tdss_mem_req_s    mem_req,
  input  wire logic                  mem_ack,
  input  wire logic [15:0]           mem_rdata,
  // Transmit engine
  output tdss_pkg::tdss_buf_s        buf_info,
  output logic                       buf_valid,
  input  wire logic                  tx_done,
  input  wire tdss_pkg::tdss_status_s tx_status,
  // Status
  output logic [6:0]                 ring_ptr,
  output logic                       retries_exhausted,
  output logic                       desc_error,
  output logic                       desc_returned
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] desc_addr(
    input logic [23:0] base,
    input logic [6:0]  ptr,
    input logic [23:0] offset
  );
    logic [23:0] idx;
    idx       = {17'h00000, ptr};
    desc_addr = base + (idx << tdss_pkg::DESC_SHIFT) + offset;
  endfunction : desc_addr

  function automatic logic [6:0] ring_mask(input logic [2:0] log2);
    ring_mask = 7'((8'h01 << log2) - 8'h01);
  endfunction : ring_mask

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tdss_pkg::tdss_state_e   state_reg, state_next;
  tdss_pkg::tdss_mem_req_s mem_reg, mem_next;
  tdss_pkg::tdss_buf_s     buf_reg, buf_next;
  logic                    bvalid_reg, bvalid_next;
  logic [15:0]             w1_reg, w1_next;
  logic [6:0]              ptr_reg, ptr_next;
  logic                    rte_reg, rte_next;
  logic                    err_reg, err_next;
  logic                    ret_reg, ret_next;

  logic                    exhausted;
  logic                    any_error;
  logic [15:0]             status_word;

  // ----------------------------------------------------------------
  // Status word composition
  // ----------------------------------------------------------------
  always_comb begin
    exhausted = tx_status.retry_count >= tdss_pkg::RETRY_LIMIT;
    any_error = tx_status.late_collision | tx_status.carrier_loss |
                tx_status.underflow | exhausted;
    // Host-owned fields copied back unchanged from the fetched word 1
    status_word = w1_reg;
    status_word[tdss_pkg::OWN_BIT]    = 1'b0;
    status_word[tdss_pkg::ERR_BIT]    = w1_reg[tdss_pkg::ERR_BIT] |
                                        any_error;
    status_word[tdss_pkg::RSV_BIT]    = 1'b0;
    status_word[tdss_pkg::MULTI_BIT]  = w1_reg[tdss_pkg::MULTI_BIT] |
                                        (tx_status.retry_count > 5'h01);
    status_word[tdss_pkg::SINGLE_BIT] = w1_reg[tdss_pkg::SINGLE_BIT] |
                                        (tx_status.retry_count == 5'h01);
    status_word[tdss_pkg::DEFER_BIT]  = w1_reg[tdss_pkg::DEFER_BIT] |
                                        tx_status.deferred;
  end

  // ----------------------------------------------------------------
  // Descriptor sequencer
  // ----------------------------------------------------------------
  // Next state only; the other groups key off the same state register
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      tdss_pkg::TDSS_IDLE: begin
        if (tx_enable) begin
          state_next = tdss_pkg::TDSS_RD_W1;
        end
      end
      tdss_pkg::TDSS_RD_W1: begin
        if (mem_ack) begin
          // Own bit clear: host still owns it, poll again, touch nothing
          if (mem_rdata[tdss_pkg::OWN_BIT]) begin
            state_next = tdss_pkg::TDSS_RD_W0;
          end else begin
            state_next = tdss_pkg::TDSS_IDLE;
          end
        end
      end
      tdss_pkg::TDSS_RD_W0: begin
        if (mem_ack) begin
          state_next = tdss_pkg::TDSS_RD_W2;
        end
      end
      tdss_pkg::TDSS_RD_W2: begin
        if (mem_ack) begin
          state_next = tdss_pkg::TDSS_SEND;
        end
      end
      tdss_pkg::TDSS_SEND: begin
        if (tx_done) begin
          state_next = tdss_pkg::TDSS_WR_W1;
        end
      end
      tdss_pkg::TDSS_WR_W1: begin
        if (mem_ack) begin
          state_next = tdss_pkg::TDSS_ADVANCE;
        end
      end
      tdss_pkg::TDSS_ADVANCE: begin
        state_next = tdss_pkg::TDSS_IDLE;
      end
      default: begin
        // Unused encoding: fall back to polling
        state_next = tdss_pkg::TDSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg <= tdss_pkg::TDSS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Shared RAM requests
  // ----------------------------------------------------------------
  // Request and qualifiers move on tx_enable in idle, on tx_done in send, and otherwise only on the acknowledge edge
  always_comb begin
    mem_next = mem_reg;
    unique case (state_reg)
      tdss_pkg::TDSS_IDLE: begin
        if (tx_enable) begin
          mem_next.req  = 1'b1;
          mem_next.we   = 1'b0;
          mem_next.addr = desc_addr(ring_base, ptr_reg,
                                    tdss_pkg::DESC_W1_OFFSET);
        end
      end
      tdss_pkg::TDSS_RD_W1: begin
        if (mem_ack) begin
          if (mem_rdata[tdss_pkg::OWN_BIT]) begin
            mem_next.addr = desc_addr(ring_base, ptr_reg,
                                      tdss_pkg::DESC_W0_OFFSET);
          end else begin
            mem_next.req = 1'b0;
          end
        end
      end
      tdss_pkg::TDSS_RD_W0: begin
        if (mem_ack) begin
          mem_next.addr = desc_addr(ring_base, ptr_reg,
                                    tdss_pkg::DESC_W2_OFFSET);
        end
      end
      tdss_pkg::TDSS_RD_W2: begin
        if (mem_ack) begin
          mem_next.req = 1'b0;
        end
      end
      tdss_pkg::TDSS_SEND: begin
        if (tx_done) begin
          // Single write carries status and the ownership release
          mem_next.req   = 1'b1;
          mem_next.we    = 1'b1;
          mem_next.addr  = desc_addr(ring_base, ptr_reg,
                                     tdss_pkg::DESC_W1_OFFSET);
          mem_next.wdata = status_word;
        end
      end
      tdss_pkg::TDSS_WR_W1: begin
        if (mem_ack) begin
          // Nothing more is written until the host hands it back
          mem_next.req = 1'b0;
          mem_next.we  = 1'b0;
        end
      end
      default: begin
        mem_next = mem_reg;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mem_reg <= '{req: 1'b0, we: 1'b0, addr: tdss_pkg::ADDR_RESET,
                   wdata: tdss_pkg::WORD_RESET};
    end else begin
      mem_reg <= mem_next;
    end
  end

  // ----------------------------------------------------------------
  // Buffer offer to the transmit engine
  // ----------------------------------------------------------------
  always_comb begin
    buf_next    = buf_reg;
    bvalid_next = bvalid_reg;
    w1_next     = w1_reg;
    unique case (state_reg)
      tdss_pkg::TDSS_RD_W1: begin
        if (mem_ack) begin
          // Kept whole so host-owned bits go back unchanged
          w1_next = mem_rdata;
        end
      end
      tdss_pkg::TDSS_RD_W0: begin
        if (mem_ack) begin
          buf_next.start_addr = {w1_reg[tdss_pkg::ADDR_HI_MSB:0],
                                 mem_rdata};
        end
      end
      tdss_pkg::TDSS_RD_W2: begin
        if (mem_ack) begin
          // Top nibble ignored; length range is the host's duty
          buf_next.length = 12'(~mem_rdata[tdss_pkg::LEN_MSB:0] +
                                12'h001);
          buf_next.first  = w1_reg[tdss_pkg::FIRST_BIT];
          buf_next.last   = w1_reg[tdss_pkg::LAST_BIT];
          buf_next.whole  = w1_reg[tdss_pkg::FIRST_BIT] &
                            w1_reg[tdss_pkg::LAST_BIT];
          bvalid_next     = 1'b1;
        end
      end
      tdss_pkg::TDSS_SEND: begin
        if (tx_done) begin
          bvalid_next = 1'b0;
        end
      end
      default: begin
        bvalid_next = bvalid_reg;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      buf_reg    <= '0;
      bvalid_reg <= 1'b0;
      w1_reg     <= tdss_pkg::WORD_RESET;
    end else begin
      buf_reg    <= buf_next;
      bvalid_reg <= bvalid_next;
      w1_reg     <= w1_next;
    end
  end

  // ----------------------------------------------------------------
  // Completion events and ring pointer
  // ----------------------------------------------------------------
  // Pulses last one cycle; exhausted level holds until the next packet
  always_comb begin
    ptr_next = ptr_reg;
    rte_next = rte_reg;
    err_next = 1'b0;
    ret_next = 1'b0;
    if ((state_reg == tdss_pkg::TDSS_SEND) && tx_done) begin
      rte_next = exhausted;
      err_next = any_error;
    end
    // Pointer moves only after the ownership release has landed
    if (state_reg == tdss_pkg::TDSS_ADVANCE) begin
      ptr_next = (ptr_reg + 7'h01) & ring_mask(ring_len_log2);
      ret_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ptr_reg <= tdss_pkg::PTR_RESET;
      rte_reg <= 1'b0;
      err_reg <= 1'b0;
      ret_reg <= 1'b0;
    end else begin
      ptr_reg <= ptr_next;
      rte_reg <= rte_next;
      err_reg <= err_next;
      ret_reg <= ret_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mem_req           = mem_reg;
  assign buf_info          = buf_reg;
  assign buf_valid         = bvalid_reg;
  assign ring_ptr          = ptr_reg;
  assign retries_exhausted = rte_reg;
  assign desc_error        = err_reg;
  assign desc_returned     = ret_reg;

endmodule : tdss_engine
